// ==== inc/tap_trim_pkg.sv ====
// constants and types shared by the tap timing and offset trim block
package tap_trim_pkg;
  // register indices (printed offsets are not multiples of four: byte address = 4 * index)
  localparam logic [7:0] idx_tap_threshold = 8'h2f;
  localparam logic [7:0] idx_tap_duration = 8'h30;
  localparam logic [7:0] idx_first_tap_latency = 8'h31;
  localparam logic [7:0] idx_second_tap_window = 8'h32;
  localparam logic [7:0] idx_x_axis_offset_trim = 8'h33;
  localparam logic [7:0] idx_y_axis_offset_trim = 8'h34;
  localparam logic [7:0] idx_z_axis_offset_trim = 8'h35;
  localparam logic [7:0] idx_factory_trim = 8'h3a;
  localparam logic [7:0] idx_irq_status = 8'h3b;
  localparam logic [7:0] idx_irq_mask = 8'h3c;
  localparam logic [7:0] idx_tap_status = 8'h3d;
  // reset values
  localparam logic [7:0] rst_byte = 8'h00;
  localparam logic [4:0] rst_trim = 5'h00;
  // field layout
  localparam int trim_msb = 4;
  localparam int trim_w = 5;
  localparam int accel_w = 14;
  // offset weight: 15 mg per trim count, accel output at 0.25 mg per lsb
  localparam int trim_mg_per_lsb_x100 = 1500;
  localparam int accel_mg_per_lsb_x100 = 25;
  localparam int trim_gain = trim_mg_per_lsb_x100 / accel_mg_per_lsb_x100;
  // timing
  localparam int clk_hz = 40000000;
  localparam int latency_tick_us_x100 = 125000;
  localparam int duration_tick_us_x100 = 62500;
  // divide first so the product stays inside 32 bits
  localparam int latency_tick_cycles = (clk_hz / 100000) * latency_tick_us_x100 / 1000;
  localparam int duration_tick_cycles = (clk_hz / 100000) * duration_tick_us_x100 / 1000;
  // interrupt bits
  localparam int irq_single = 0;
  localparam int irq_double = 1;
  localparam int irq_w = 2;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_above = 2'b01,
    st_latency = 2'b10,
    st_window = 2'b11
  } tap_state_t;
endpackage : tap_trim_pkg

// ==== inc/trim_if.sv ====
// per-axis trim values and factory trim passed to the offset adder
interface trim_if;
  logic signed [4:0] user_trim [3];
  logic signed [4:0] factory_trim;
  modport src (output user_trim, output factory_trim);
  modport dst (input user_trim, input factory_trim);
endinterface : trim_if

// ==== rtl/offset_apply.sv ====
// applies user plus factory offset trim to each axis sample
module offset_apply (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // trims
  trim_if.dst trims,
  // samples
  input wire logic signed [13:0] raw [3],
  output logic signed [13:0] corr [3]
);
  genvar a;
  generate
    for (a = 0; a < 3; a++) begin : g_axis
      logic signed [6:0] sum;
      logic signed [6:0] lim;
      logic signed [15:0] adj;
      logic signed [16:0] res;
      logic signed [13:0] sat;
      // both trims share one 5-bit headroom, so the total saturates there
      assign sum = 7'(trims.user_trim[a]) + 7'(trims.factory_trim);
      assign lim = (sum > 7'sd15) ? 7'sd15 : ((sum < -7'sd16) ? -7'sd16 : sum);
      assign adj = 16'(lim) * 16'(tap_trim_pkg::trim_gain);
      assign res = 17'(raw[a]) + 17'(adj);
      assign sat = (res > 17'sd8191) ? 14'sh1fff : ((res < -17'sd8192) ? 14'sh2000 : res[13:0]);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          corr[a] <= 14'sh0000;
        end else begin
          corr[a] <= sat;
        end
      end
    end
  endgenerate
endmodule : offset_apply

// ==== rtl/tap_timing_offset_trim_regs.sv ====
// tap timing and axis offset trim register bank with tap detector
//
// Implementation choice: the APB register port.
module tap_timing_offset_trim_regs (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sample path
  input wire logic sample_valid,
  input wire logic [7:0] tap_magnitude,
  input wire logic signed [13:0] raw_x,
  input wire logic signed [13:0] raw_y,
  input wire logic signed [13:0] raw_z,
  output logic signed [13:0] corr_x,
  output logic signed [13:0] corr_y,
  output logic signed [13:0] corr_z,
  // events
  output logic single_tap,
  output logic double_tap,
  output logic irq
);
  logic [7:0] threshold_reg;
  logic [7:0] duration_reg;
  logic [7:0] latency_reg;
  logic [7:0] window_reg;
  logic [4:0] trim_reg [3];
  logic [4:0] factory_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic single_reg;
  logic double_reg;
  tap_trim_pkg::tap_state_t state_reg;
  tap_trim_pkg::tap_state_t state_next;
  logic [8:0] above_cnt_reg;
  logic [8:0] time_cnt_reg;
  logic first_done_reg;
  logic [31:0] prdata_reg;

  // bus decode: registers are word aligned, index is paddr[9:2]
  logic [7:0] idx;
  logic acc;
  logic wr;
  logic rd;
  logic hit;
  logic addr_ok;
  logic wr_en;
  assign idx = paddr[9:2];
  assign acc = psel && penable;
  assign hit = (idx >= tap_trim_pkg::idx_tap_threshold && idx <= tap_trim_pkg::idx_z_axis_offset_trim)
      || (idx >= tap_trim_pkg::idx_factory_trim && idx <= tap_trim_pkg::idx_tap_status);
  // upper address bits must be zero, else the index would alias
  assign addr_ok = hit && (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign wr = acc && pwrite;
  // read data loaded in the setup cycle so it stands at the access edge
  assign rd = psel && !penable && !pwrite;
  assign wr_en = wr && addr_ok && pstrb[0];
  assign pready = 1'b1;
  assign pslverr = acc && !addr_ok;
  assign prdata = prdata_reg;

  function automatic logic wsel(input logic [7:0] i, input logic [7:0] r);
    wsel = (i == r);
  endfunction : wsel

  logic [7:0] rd_mux;
  assign rd_mux =
      (idx == tap_trim_pkg::idx_tap_threshold) ? threshold_reg :
      (idx == tap_trim_pkg::idx_tap_duration) ? duration_reg :
      (idx == tap_trim_pkg::idx_first_tap_latency) ? latency_reg :
      (idx == tap_trim_pkg::idx_second_tap_window) ? window_reg :
      (idx == tap_trim_pkg::idx_x_axis_offset_trim) ? {3'h0, trim_reg[0]} :
      (idx == tap_trim_pkg::idx_y_axis_offset_trim) ? {3'h0, trim_reg[1]} :
      (idx == tap_trim_pkg::idx_z_axis_offset_trim) ? {3'h0, trim_reg[2]} :
      (idx == tap_trim_pkg::idx_factory_trim) ? {3'h0, factory_reg} :
      (idx == tap_trim_pkg::idx_irq_status) ? {6'h00, irq_status_reg} :
      (idx == tap_trim_pkg::idx_irq_mask) ? {6'h00, irq_mask_reg} :
      (idx == tap_trim_pkg::idx_tap_status) ? {5'h00, (state_reg != tap_trim_pkg::st_idle), double_reg, single_reg} :
      8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (rd) begin
      prdata_reg <= addr_ok ? {24'h000000, rd_mux} : 32'h00000000;
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      threshold_reg <= tap_trim_pkg::rst_byte;
      duration_reg <= tap_trim_pkg::rst_byte;
      latency_reg <= tap_trim_pkg::rst_byte;
      window_reg <= tap_trim_pkg::rst_byte;
      factory_reg <= tap_trim_pkg::rst_trim;
      irq_mask_reg <= 2'h0;
    end else if (wr_en) begin
      if (wsel(idx, tap_trim_pkg::idx_tap_threshold)) threshold_reg <= pwdata[7:0];
      if (wsel(idx, tap_trim_pkg::idx_tap_duration)) duration_reg <= pwdata[7:0];
      if (wsel(idx, tap_trim_pkg::idx_first_tap_latency)) latency_reg <= pwdata[7:0];
      if (wsel(idx, tap_trim_pkg::idx_second_tap_window)) window_reg <= pwdata[7:0];
      if (wsel(idx, tap_trim_pkg::idx_factory_trim)) factory_reg <= pwdata[4:0];
      if (wsel(idx, tap_trim_pkg::idx_irq_mask)) irq_mask_reg <= pwdata[1:0];
    end
  end

  genvar a;
  generate
    for (a = 0; a < 3; a++) begin : g_trim
      logic sel;
      assign sel = wr_en && (idx == tap_trim_pkg::idx_x_axis_offset_trim + 8'(a));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          trim_reg[a] <= tap_trim_pkg::rst_trim;
        end else if (sel) begin
          trim_reg[a] <= pwdata[tap_trim_pkg::trim_msb:0];
        end
      end
    end
  endgenerate

  // offset path
  trim_if trims ();
  assign trims.user_trim[0] = $signed(trim_reg[0]);
  assign trims.user_trim[1] = $signed(trim_reg[1]);
  assign trims.user_trim[2] = $signed(trim_reg[2]);
  assign trims.factory_trim = $signed(factory_reg);
  logic signed [13:0] raw_v [3];
  logic signed [13:0] corr_v [3];
  assign raw_v[0] = raw_x;
  assign raw_v[1] = raw_y;
  assign raw_v[2] = raw_z;
  assign corr_x = corr_v[0];
  assign corr_y = corr_v[1];
  assign corr_z = corr_v[2];
  offset_apply u_offset (
    .pclk(pclk),
    .presetn(presetn),
    .trims(trims.dst),
    .raw(raw_v),
    .corr(corr_v)
  );

  // timer ticks
  logic lat_tick;
  logic dur_tick;
  tick_gen #(.period(tap_trim_pkg::latency_tick_cycles)) u_lat_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(lat_tick)
  );
  tick_gen #(.period(tap_trim_pkg::duration_tick_cycles)) u_dur_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(dur_tick)
  );

  // tap detector
  logic enabled;
  logic above;
  logic tap_end;
  logic tap_ok;
  logic time_up;
  assign enabled = (threshold_reg != 8'h00);
  assign above = enabled && sample_valid && (tap_magnitude > threshold_reg);
  assign tap_end = sample_valid && !(tap_magnitude > threshold_reg);
  // duration is a maximum: a long push is not a tap
  assign tap_ok = (above_cnt_reg <= {1'b0, duration_reg});
  assign time_up = lat_tick && (time_cnt_reg == 9'h000);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tap_trim_pkg::st_idle: begin
        if (above) state_next = tap_trim_pkg::st_above;
      end
      tap_trim_pkg::st_above: begin
        if (!enabled) state_next = tap_trim_pkg::st_idle;
        else if (tap_end) state_next = (tap_ok && !first_done_reg && latency_reg != 8'h00)
            ? tap_trim_pkg::st_latency : tap_trim_pkg::st_idle;
      end
      tap_trim_pkg::st_latency: begin
        if (!enabled) state_next = tap_trim_pkg::st_idle;
        else if (time_up) state_next = (window_reg == 8'h00) ? tap_trim_pkg::st_idle : tap_trim_pkg::st_window;
      end
      tap_trim_pkg::st_window: begin
        if (!enabled || time_up) state_next = tap_trim_pkg::st_idle;
        else if (above) state_next = tap_trim_pkg::st_above;
      end
      default: state_next = tap_trim_pkg::st_idle;
    endcase
  end

  logic single_ev;
  logic double_ev;
  logic enter_above;
  // a single tap is reported at its end when latency is zero, or when the second-tap window runs out
  assign single_ev = (state_reg == tap_trim_pkg::st_above && enabled && tap_end && tap_ok && !first_done_reg
      && latency_reg == 8'h00)
      || (state_reg == tap_trim_pkg::st_window && enabled && time_up);
  assign double_ev = state_reg == tap_trim_pkg::st_above && enabled && tap_end && tap_ok && first_done_reg;
  assign enter_above = state_next == tap_trim_pkg::st_above && state_reg != tap_trim_pkg::st_above;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= tap_trim_pkg::st_idle;
      above_cnt_reg <= 9'h000;
      time_cnt_reg <= 9'h000;
      first_done_reg <= 1'b0;
      single_reg <= 1'b0;
      double_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      single_reg <= single_ev;
      double_reg <= double_ev;
      if (enter_above) above_cnt_reg <= 9'h000;
      else if (dur_tick && above_cnt_reg != 9'h1ff) above_cnt_reg <= above_cnt_reg + 9'h001;
      if (state_next == tap_trim_pkg::st_latency && state_reg != tap_trim_pkg::st_latency) begin
        time_cnt_reg <= {1'b0, latency_reg} - 9'h001;
      end else if (state_next == tap_trim_pkg::st_window && state_reg == tap_trim_pkg::st_latency) begin
        time_cnt_reg <= {1'b0, window_reg} - 9'h001;
      end else if (lat_tick && time_cnt_reg != 9'h000) begin
        time_cnt_reg <= time_cnt_reg - 9'h001;
      end
      if (state_next == tap_trim_pkg::st_idle || state_next == tap_trim_pkg::st_latency) first_done_reg <= 1'b0;
      if (state_reg == tap_trim_pkg::st_window && state_next == tap_trim_pkg::st_above) first_done_reg <= 1'b1;
    end
  end
  assign single_tap = single_reg;
  assign double_tap = double_reg;

  // sticky interrupt status: set beats write-one-to-clear
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  assign irq_set = {double_ev, single_ev};
  assign irq_clr = (wr_en && idx == tap_trim_pkg::idx_irq_status) ? pwdata[1:0] : 2'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= 2'h0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
    end
  end
  assign irq = |(irq_status_reg & irq_mask_reg);

  a_zero_thresh_idle: assert property (@(posedge pclk) disable iff (!presetn)
      (threshold_reg == 8'h00) |=> ##1 !single_reg && !double_reg)
    else $error("tap reported with zero threshold");
  a_no_double_lat0: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == tap_trim_pkg::st_above && latency_reg == 8'h00 && !first_done_reg && tap_end)
      |-> state_next != tap_trim_pkg::st_latency)
    else $error("double tap search opened with zero latency");
  a_double_in_window: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == tap_trim_pkg::st_idle && state_next == tap_trim_pkg::st_above) |=> !first_done_reg)
    else $error("tap from idle taken as second tap");
  a_latency_ignores: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == tap_trim_pkg::st_latency && above) |=> state_reg != tap_trim_pkg::st_above)
    else $error("tap accepted during latency");
  a_long_push_rejected: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == tap_trim_pkg::st_above && above_cnt_reg > {1'b0, duration_reg}) |-> !single_ev && !double_ev)
    else $error("over-long push counted as tap");
  a_offset_rsv_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (rd && idx == tap_trim_pkg::idx_y_axis_offset_trim) |=> prdata[7:5] == 3'h0)
    else $error("offset reserved bits not zero");
  a_window_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && idx == tap_trim_pkg::idx_second_tap_window) |=> window_reg == $past(pwdata[7:0]))
    else $error("window write lost");
  a_latency_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && idx == tap_trim_pkg::idx_first_tap_latency) |=> latency_reg == $past(pwdata[7:0]))
    else $error("latency write lost");
  a_trim_sign: assert property (@(posedge pclk) disable iff (!presetn)
      trims.user_trim[0] < 0 |-> trim_reg[0][4])
    else $error("trim sign bit misread");
  a_irq_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      single_ev |=> irq_status_reg[tap_trim_pkg::irq_single])
    else $error("single tap status not set");
  c_single: cover property (@(posedge pclk) disable iff (!presetn) single_ev);
  c_double: cover property (@(posedge pclk) disable iff (!presetn) double_ev);
  c_window: cover property (@(posedge pclk) disable iff (!presetn) state_reg == tap_trim_pkg::st_window);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
  c_long_push: cover property (@(posedge pclk) disable iff (!presetn)
      state_reg == tap_trim_pkg::st_above && tap_end && !tap_ok);
endmodule : tap_timing_offset_trim_regs

// ==== rtl/tick_gen.sv ====
// free-running tick generator for the tap timers
module tick_gen #(
  parameter int period = 50000
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // tick out
  output logic tick
);
  logic [31:0] cnt_reg;
  logic wrap;
  assign wrap = (cnt_reg == 32'(period - 1));
  assign tick = wrap;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 32'h00000000;
    end else begin
      cnt_reg <= wrap ? 32'h00000000 : cnt_reg + 32'h00000001;
    end
  end
endmodule : tick_gen

// ==== verif/tap_timing_offset_trim_regs_tb.sv ====
// self-checking bench for the tap timing and offset trim register bank
module tap_timing_offset_trim_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sample_valid = 1'b1;
  logic [7:0] tap_magnitude = 8'h00;
  logic signed [13:0] raw_x = 14'h0000;
  logic signed [13:0] raw_y = 14'h0000;
  logic signed [13:0] raw_z = 14'h0000;
  logic signed [13:0] corr_x;
  logic signed [13:0] corr_y;
  logic signed [13:0] corr_z;
  logic single_tap;
  logic double_tap;
  logic irq;
  int num_errors = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic rd_err;
  logic [7:0] all_idx [7] = '{tap_trim_pkg::idx_tap_threshold, tap_trim_pkg::idx_tap_duration,
    tap_trim_pkg::idx_first_tap_latency, tap_trim_pkg::idx_second_tap_window, tap_trim_pkg::idx_x_axis_offset_trim,
    tap_trim_pkg::idx_y_axis_offset_trim, tap_trim_pkg::idx_z_axis_offset_trim};

  tap_timing_offset_trim_regs tap_timing_offset_trim_regs_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .tap_magnitude(tap_magnitude), .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z),
    .corr_x(corr_x), .corr_y(corr_y), .corr_z(corr_z), .single_tap(single_tap), .double_tap(double_tap),
    .irq(irq)
  );

  always #12.5 pclk = ~pclk;

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  // one apb transfer; holds the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      num_errors++;
      $display("[ERR] %0t no pready", $time);
      test_done();
    end
    rd_err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle cycle so back-to-back calls never reassign psel in one step
    @(posedge pclk);
  endtask : apb

  task automatic tap(input logic [7:0] mag);
    tap_magnitude <= mag;
    repeat (4) @(posedge pclk);
    tap_magnitude <= 8'h00;
  endtask : tap

  // counts pulses over a bounded number of cycles
  task automatic watch(input int cycles, output int singles, output int doubles);
    singles = 0;
    doubles = 0;
    repeat (cycles) begin
      @(posedge pclk);
      if (single_tap === 1'b1) singles++;
      if (double_tap === 1'b1) doubles++;
    end
  endtask : watch

  task automatic t_regs;
    foreach (all_idx[i]) begin
      apb(1'b0, all_idx[i], 8'h00);
      cmp(rd, 32'h0, "reset value");
    end
    apb(1'b1, tap_trim_pkg::idx_second_tap_window, 8'ha5);
    apb(1'b0, tap_trim_pkg::idx_second_tap_window, 8'h00);
    cmp(rd, 32'ha5, "window rw");
    apb(1'b1, tap_trim_pkg::idx_first_tap_latency, 8'h5a);
    apb(1'b0, tap_trim_pkg::idx_first_tap_latency, 8'h00);
    cmp(rd, 32'h5a, "latency rw");
    pstrb <= 4'h0;
    apb(1'b1, tap_trim_pkg::idx_second_tap_window, 8'h11);
    pstrb <= 4'hf;
    apb(1'b0, tap_trim_pkg::idx_second_tap_window, 8'h00);
    cmp(rd, 32'ha5, "strobe-less write ignored");
    apb(1'b0, 8'h00, 8'h00);
    cmp({31'h0, rd_err}, 32'h1, "unmapped err");
    cmp(rd, 32'h0, "unmapped data");
    $display("register test done");
  endtask : t_regs

  task automatic t_trims;
    raw_x <= 14'sd100;
    raw_y <= 14'sd100;
    raw_z <= 14'sd100;
    apb(1'b1, tap_trim_pkg::idx_x_axis_offset_trim, 8'hff);
    apb(1'b1, tap_trim_pkg::idx_y_axis_offset_trim, 8'h0f);
    apb(1'b1, tap_trim_pkg::idx_z_axis_offset_trim, 8'h10);
    apb(1'b0, tap_trim_pkg::idx_x_axis_offset_trim, 8'h00);
    cmp(rd, 32'h1f, "reserved bits");
    repeat (2) @(posedge pclk);
    cmp(32'(corr_x), 32'(100 - tap_trim_pkg::trim_gain), "x trim -1");
    cmp(32'(corr_y), 32'(100 + 15 * tap_trim_pkg::trim_gain), "y trim +15");
    cmp(32'(corr_z), 32'(100 - 16 * tap_trim_pkg::trim_gain), "z trim -16");
    // factory trim shares the 5-bit range, so y pins at +15
    apb(1'b1, tap_trim_pkg::idx_factory_trim, 8'h05);
    repeat (2) @(posedge pclk);
    cmp(32'(corr_x), 32'(100 + 4 * tap_trim_pkg::trim_gain), "x plus factory");
    cmp(32'(corr_y), 32'(100 + 15 * tap_trim_pkg::trim_gain), "y headroom");
    cmp(32'(corr_z), 32'(100 - 11 * tap_trim_pkg::trim_gain), "z plus factory");
    $display("trim test done");
  endtask : t_trims

  task automatic t_single_irq;
    int s;
    int d;
    apb(1'b1, tap_trim_pkg::idx_tap_threshold, 8'h10);
    apb(1'b1, tap_trim_pkg::idx_tap_duration, 8'h02);
    apb(1'b1, tap_trim_pkg::idx_first_tap_latency, 8'h00);
    tap(8'h40);
    watch(60, s, d);
    cmp(32'(s), 32'd1, "single with zero latency");
    cmp(32'(d), 32'd0, "no double with zero latency");
    cmp({31'h0, irq}, 32'h0, "masked irq");
    apb(1'b0, tap_trim_pkg::idx_irq_status, 8'h00);
    cmp(rd, 32'h1, "single status");
    apb(1'b1, tap_trim_pkg::idx_irq_mask, 8'h03);
    cmp({31'h0, irq}, 32'h1, "unmasked irq");
    apb(1'b1, tap_trim_pkg::idx_irq_status, 8'h01);
    cmp({31'h0, irq}, 32'h0, "irq cleared");
    // zero duration: a press spanning one duration tick is too long
    apb(1'b1, tap_trim_pkg::idx_tap_duration, 8'h00);
    tap_magnitude <= 8'h40;
    repeat (tap_trim_pkg::duration_tick_cycles + 4) @(posedge pclk);
    tap_magnitude <= 8'h00;
    watch(60, s, d);
    cmp(32'(s + d), 32'd0, "long press");
    apb(1'b1, tap_trim_pkg::idx_tap_duration, 8'h02);
    $display("single tap test done");
  endtask : t_single_irq

  task automatic t_no_thresh;
    int s;
    int d;
    apb(1'b1, tap_trim_pkg::idx_tap_threshold, 8'h00);
    tap(8'hff);
    watch(60, s, d);
    cmp(32'(s + d), 32'd0, "zero threshold");
    $display("zero threshold test done");
  endtask : t_no_thresh

  task automatic t_double;
    int s;
    int d;
    apb(1'b1, tap_trim_pkg::idx_tap_threshold, 8'h10);
    apb(1'b1, tap_trim_pkg::idx_first_tap_latency, 8'h01);
    apb(1'b1, tap_trim_pkg::idx_second_tap_window, 8'h02);
    tap(8'h40);
    // latency ends within one tick, window spans two aligned ticks after it
    watch(tap_trim_pkg::latency_tick_cycles + 5000, s, d);
    cmp(32'(s + d), 32'd0, "quiet before second tap");
    tap(8'h40);
    watch(60, s, d);
    cmp(32'(d), 32'd1, "double tap");
    cmp(32'(s), 32'd0, "double suppresses single");
    apb(1'b0, tap_trim_pkg::idx_irq_status, 8'h00);
    cmp(rd, 32'h2, "double status");
    $display("double tap test done");
  endtask : t_double

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_trims();
    t_single_irq();
    t_no_thresh();
    t_double();
    test_done();
  end
endmodule : tap_timing_offset_trim_regs_tb
